//--- core/srap_defines.svh
// Constants of the serial register access port: field widths and timing.
// Assumes inclusion by the package, host and device files; holds definitions only.
`ifndef SRAP_DEFINES_SVH
`define SRAP_DEFINES_SVH

// ****************************************************************
// Frame layout
// ****************************************************************
`define SRAP_INSTR_BITS     5
`define SRAP_ADDR_BITS      11
`define SRAP_DATA_BITS      8
`define SRAP_HDR_BITS       16
`define SRAP_DIR_POS        4
`define SRAP_DIR_READ       1'b1
`define SRAP_DIR_WRITE      1'b0
`define SRAP_CNT_RST        5'h00
`define SRAP_DATA_RST       8'h00
`define SRAP_REG_DEPTH      2048

// ****************************************************************
// Timing
// ****************************************************************
`define SRAP_SCLK_HALF_NS   250
`define SRAP_SYS_CLK_NS     100
`define SRAP_SCLK_HALF_CYC  ((`SRAP_SCLK_HALF_NS + `SRAP_SYS_CLK_NS - 1) / `SRAP_SYS_CLK_NS)
`define SRAP_CS_HIGH_NS     100
`define SRAP_CS_HIGH_CYC    ((`SRAP_CS_HIGH_NS + `SRAP_SYS_CLK_NS - 1) / `SRAP_SYS_CLK_NS)

`endif

//--- core/srap_pkg.sv
// Types shared by both ends of the serial register access port.
// Assumes srap_defines.svh is on the include path.
`include "srap_defines.svh"

package srap_pkg;

	typedef logic [`SRAP_INSTR_BITS-1:0] srap_instr_t;
	typedef logic [`SRAP_ADDR_BITS-1:0]  srap_addr_t;
	typedef logic [`SRAP_DATA_BITS-1:0]  srap_data_t;

	typedef enum logic [2:0] {
		SRAP_H_IDLE  = 3'b000,
		SRAP_H_SETUP = 3'b001,
		SRAP_H_LOW   = 3'b010,
		SRAP_H_HIGH  = 3'b011,
		SRAP_H_GAP   = 3'b100
	} srap_hstate_t;

endpackage : srap_pkg

//--- core/srap_if.sv
// Four-wire link plus output enable between host master and device slave.
// Assumes serial_out is sampled by the host only while select is low.
`timescale 1ns/1ps

interface srap_if;
	logic cs_n;
	logic sclk;
	logic serial_in;
	logic serial_out;
	logic serial_out_oe;

	modport host (
		output cs_n,
		output sclk,
		output serial_in,
		input  serial_out,
		input  serial_out_oe
	);

	modport device (
		input  cs_n,
		input  sclk,
		input  serial_in,
		output serial_out,
		output serial_out_oe
	);
endinterface : srap_if

//--- core/srap_sync.sv
// Three-stage synchroniser with agreement on the last two stages.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ps

module srap_sync
	import srap_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_async,
	input  wire logic i_rst_val,
	output logic      o_level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic lvl_r;
	wire  agree = (s2_r == s3_r);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s1_r  <= 1'b0;
			s2_r  <= 1'b0;
			s3_r  <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree)
				lvl_r <= s3_r;
		end
	end

	assign o_level = i_rst_n ? lvl_r : i_rst_val;
endmodule : srap_sync

//--- core/srap_device.sv
// Device end: serial slave clocked by the link clock, 2048 x 8 registers.
// Assumes the host keeps sclk low between frames and cs_n bounds frames.
`timescale 1ns/1ps
`include "srap_defines.svh"

module srap_device
	import srap_pkg::*;
(
	srap_if.device     link,
	input  wire logic  i_link_rst_n,
	output srap_addr_t o_last_addr,
	output srap_data_t o_last_wdata,
	output logic       o_wr_pulse
);
	// ****************************************************************
	// Storage and shift state
	// ****************************************************************
	srap_data_t                  regs [`SRAP_REG_DEPTH];
	logic [4:0]                  cnt_r;
	logic [`SRAP_HDR_BITS-1:0]   hdr_r;
	srap_data_t                  wsh_r;
	srap_data_t                  rsh_r;
	logic                        so_r;
	logic                        oe_r;
	srap_addr_t                  addr_r;
	srap_data_t                  rdat_r;
	srap_addr_t                  last_addr_r;
	srap_data_t                  last_wdata_r;
	logic                        wr_r;

	// ****************************************************************
	// Frame decoding
	// ****************************************************************
	// Direction flag heads the header
	function automatic logic srap_dir_of(
		input logic [`SRAP_HDR_BITS-1:0] hdr
	);
		return hdr[`SRAP_HDR_BITS-1];
	endfunction : srap_dir_of

	// Register index in the low header bits
	function automatic srap_addr_t srap_addr_of(
		input logic [`SRAP_HDR_BITS-1:0] hdr
	);
		return hdr[`SRAP_ADDR_BITS-1:0];
	endfunction : srap_addr_of

	// Rises seen so far equal a frame position
	function automatic logic srap_at(
		input logic [4:0] cnt,
		input logic [4:0] pos
	);
		return cnt == pos;
	endfunction : srap_at

	wire active   = !link.cs_n;
	wire hdr_done = srap_at(cnt_r, 5'(`SRAP_HDR_BITS));
	wire addr_ok  = srap_at(cnt_r, 5'(`SRAP_HDR_BITS - 1));
	wire last_wr  = srap_at(cnt_r,
		5'(`SRAP_HDR_BITS + `SRAP_DATA_BITS - 1));
	wire cnt_full = srap_at(cnt_r, 5'h1F);
	wire data_ph  = (cnt_r >= 5'(`SRAP_HDR_BITS));
	wire dir_rd   = (srap_dir_of(hdr_r) == `SRAP_DIR_READ);
	wire [`SRAP_HDR_BITS-1:0]  hdr_nxt   = {hdr_r[`SRAP_HDR_BITS-2:0],
		link.serial_in};
	wire [`SRAP_DATA_BITS-1:0] wdata_nxt = {wsh_r[`SRAP_DATA_BITS-2:0],
		link.serial_in};
	// Store only in a write frame
	wire store_en  = active && last_wr && !dir_rd;
	wire launch_go = hdr_done && dir_rd && !oe_r;
	wire [`SRAP_DATA_BITS-1:0] rsh_src = launch_go ? rdat_r : rsh_r;
	wire [`SRAP_DATA_BITS-1:0] rsh_nxt = {rsh_src[`SRAP_DATA_BITS-2:0],
		1'b0};

	// ****************************************************************
	// Rising sclk: capture, cleared asynchronously by select high
	// ****************************************************************
	// Fresh count on select fall
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			cnt_r <= `SRAP_CNT_RST;
		end else if (!cnt_full) begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			hdr_r <= '0;
		end else if (!data_ph) begin
			hdr_r <= hdr_nxt;
		end
	end

	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			wsh_r <= `SRAP_DATA_RST;
		end else if (data_ph) begin
			wsh_r <= wdata_nxt;
		end
	end

	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			addr_r <= '0;
		end else if (addr_ok) begin
			addr_r <= srap_addr_of(hdr_nxt);
		end
	end

	// ****************************************************************
	// Register array: no reset, unwritten entries read unknown
	// ****************************************************************
	// Store write data at eighth bit
	always_ff @(posedge link.sclk) begin
		if (store_en) begin
			regs[addr_r] <= wdata_nxt;
		end
	end

	// Fetch addressed value as address completes
	always_ff @(posedge link.sclk) begin
		if (active && addr_ok) begin
			rdat_r <= regs[srap_addr_of(hdr_nxt)];
		end
	end

	// ****************************************************************
	// Write report toward the user side
	// ****************************************************************
	always_ff @(posedge link.sclk) begin
		if (!i_link_rst_n) begin
			wr_r <= 1'b0;
		end else begin
			wr_r <= store_en;
		end
	end

	always_ff @(posedge link.sclk) begin
		if (!i_link_rst_n) begin
			last_addr_r  <= '0;
			last_wdata_r <= `SRAP_DATA_RST;
		end else if (store_en) begin
			last_addr_r  <= addr_r;
			last_wdata_r <= wdata_nxt;
		end
	end

	// ****************************************************************
	// Falling sclk: read data launch
	// ****************************************************************
	// Launch on falling edge after address
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			so_r <= 1'b0;
		end else if (launch_go || oe_r) begin
			so_r <= rsh_src[`SRAP_DATA_BITS-1];
		end
	end

	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			rsh_r <= `SRAP_DATA_RST;
		end else if (launch_go || oe_r) begin
			rsh_r <= rsh_nxt;
		end
	end

	// Output enable stays up until select rises
	always_ff @(negedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			oe_r <= 1'b0;
		end else if (launch_go) begin
			oe_r <= 1'b1;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign link.serial_out    = so_r;
	assign link.serial_out_oe = oe_r;
	assign o_last_addr        = last_addr_r;
	assign o_last_wdata       = last_wdata_r;
	assign o_wr_pulse         = wr_r;
endmodule : srap_device

//--- core/srap_host.sv
// Host end: serial master, makes sclk from i_clk by division.
// Assumes the user holds request fields stable while i_req is high.
`timescale 1ns/1ps
`include "srap_defines.svh"

module srap_host
	import srap_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_req,
	input  wire logic       i_read,
	input  wire srap_addr_t i_addr,
	input  wire srap_data_t i_wdata,
	output logic            o_busy,
	output logic            o_done,
	output srap_data_t      o_rdata,
	srap_if.host            link
);
	// ****************************************************************
	// State
	// ****************************************************************
	srap_hstate_t st_r;
	logic [2:0]   tmr_r;
	logic [4:0]   bit_r;
	logic [23:0]  sh_r;
	srap_data_t   rd_r;
	logic         cs_r;
	logic         sclk_r;
	logic         si_r;
	logic         busy_r;
	logic         done_r;
	logic         so_s;

	// Serial data is sampled through the three-stage filter
	srap_sync u_so_sync (
		.i_clk     (i_clk),
		.i_rst_n   (i_rst_n),
		.i_async   (link.serial_out),
		.i_rst_val (1'b0),
		.o_level   (so_s)
	);

	wire tmr_end  = (tmr_r == 3'(`SRAP_SCLK_HALF_CYC - 1));
	wire last_bit = (bit_r == 5'(`SRAP_HDR_BITS + `SRAP_DATA_BITS - 1));
	wire [23:0] frame = {i_read, 4'h0, i_addr, i_wdata};

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_r   <= SRAP_H_IDLE;
			tmr_r  <= 3'h0;
			bit_r  <= 5'h00;
			sh_r   <= 24'h00_0000;
			rd_r   <= `SRAP_DATA_RST;
			cs_r   <= 1'b1;
			sclk_r <= 1'b0;
			si_r   <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			tmr_r  <= tmr_end ? 3'h0 : tmr_r + 3'h1;
			unique case (st_r)
			SRAP_H_IDLE: begin
				tmr_r <= 3'h0;
				if (i_req) begin
					cs_r   <= 1'b0;
					busy_r <= 1'b1;
					sh_r   <= {frame[22:0], 1'b0};
					si_r   <= frame[23];
					bit_r  <= 5'h00;
					st_r   <= SRAP_H_SETUP;
				end
			end
			SRAP_H_SETUP: if (tmr_end) begin
				st_r <= SRAP_H_HIGH;
				sclk_r <= 1'b1;
			end
			SRAP_H_HIGH: if (tmr_end) begin
				sclk_r <= 1'b0;
				if (bit_r >= 5'(`SRAP_HDR_BITS))
					rd_r <= {rd_r[`SRAP_DATA_BITS-2:0], so_s};
				if (last_bit)
					st_r <= SRAP_H_GAP;
				else begin
					si_r  <= sh_r[23];
					sh_r  <= {sh_r[22:0], 1'b0};
					bit_r <= bit_r + 5'h01;
					st_r  <= SRAP_H_LOW;
				end
			end
			SRAP_H_LOW: if (tmr_end) begin
				sclk_r <= 1'b1;
				st_r   <= SRAP_H_HIGH;
			end
			SRAP_H_GAP: if (tmr_end) begin
				if (cs_r == 1'b0) begin
					cs_r <= 1'b1;
				end else begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
					st_r   <= SRAP_H_IDLE;
				end
			end
			default: st_r <= SRAP_H_IDLE;
			endcase
		end
	end

	assign link.cs_n      = cs_r;
	assign link.sclk      = sclk_r;
	assign link.serial_in = si_r;
	assign o_busy         = busy_r;
	assign o_done         = done_r;
	assign o_rdata        = rd_r;
endmodule : srap_host

//--- tb/srap_assertions.sv
// Checker for the serial link between host and device.
// Assumes sclk and cs_n are host registers on i_clk.
`timescale 1ns/1ps

module srap_assertions (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	// ********************************
	// Frame tracking
	// ********************************
	logic [4:0] rise_cnt_r;
	logic       dir_r;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || cs_n)
			rise_cnt_r <= 5'h00;
		else if ($rose(sclk))
			rise_cnt_r <= rise_cnt_r + 5'h01;
	end

	always_ff @(posedge i_clk) begin
		if ($rose(sclk) && rise_cnt_r == 5'h00)
			dir_r <= serial_in;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_idle_clk_low:
		assert property (cs_n |-> !sclk)
		else $error("sclk high while deselected");
	a_select_setup:
		assert property ($fell(cs_n) |-> !sclk[*3] ##1 sclk)
		else $error("first sclk rise not three cycles after select");
	a_clk_high:
		assert property ($rose(sclk) |-> sclk[*3] ##1 !sclk)
		else $error("sclk high phase not three cycles");
	a_in_stable:
		assert property (sclk |-> $stable(serial_in))
		else $error("serial_in moved while sclk high");
	a_frame_len:
		assert property ($rose(cs_n) |-> rise_cnt_r == 5'h18)
		else $error("frame did not hold 24 sclk rises");
	a_oe_select:
		assert property (serial_out_oe |-> !cs_n)
		else $error("serial_out driven while deselected");
	a_oe_read:
		assert property (serial_out_oe |-> dir_r)
		else $error("serial_out driven in a write frame");
	a_out_launch:
		assert property (serial_out_oe && $past(serial_out_oe) && sclk
			|-> $stable(serial_out))
		else $error("serial_out moved while sclk high");
endmodule : srap_assertions

//--- tb/testbench.sv
// Self-checking bench: host and device joined over the link.
// Assumes the core files are compiled first.
`timescale 1ns/1ps

module testbench import srap_pkg::*;;
	// ********************************
	// Harness
	// ********************************
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_req = 1'b0;
	logic        i_read = 1'b0;
	srap_addr_t  i_addr = 11'h000;
	srap_data_t  i_wdata = 8'h00;
	logic        o_busy;
	logic        o_done;
	logic        o_wr_pulse;
	srap_data_t  o_rdata;
	srap_data_t  o_last_wdata;
	srap_addr_t  o_last_addr;
	logic [23:0] frame_in;
	logic [23:0] frame_out;
	int          failures = 0;
	int          check_count = 0;
	int          frames = 0;
	int          writes = 0;
	srap_data_t  mem [srap_addr_t];

	srap_if link ();
	always #50 i_clk = ~i_clk;

	srap_host srap_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_req(i_req), .i_read(i_read), .i_addr(i_addr),
		.i_wdata(i_wdata), .o_busy(o_busy), .o_done(o_done),
		.o_rdata(o_rdata), .link(link));
	srap_device srap_device_inst (.link(link), .i_link_rst_n(i_rst_n),
		.o_last_addr(o_last_addr), .o_last_wdata(o_last_wdata),
		.o_wr_pulse(o_wr_pulse));
	srap_assertions srap_assertions_inst (.i_clk(i_clk),
		.i_rst_n(i_rst_n), .cs_n(link.cs_n), .sclk(link.sclk),
		.serial_in(link.serial_in), .serial_out(link.serial_out),
		.serial_out_oe(link.serial_out_oe));

	always @(negedge link.cs_n) frames++;
	always @(posedge o_wr_pulse) writes++;
	always @(posedge link.sclk) begin
		frame_in = {frame_in[22:0], link.serial_in};
		frame_out = {frame_out[22:0], link.serial_out};
	end

	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic op(logic rd, srap_addr_t a, srap_data_t d);
		int f;
		int w;
		int n;
		f = frames;
		w = writes;
		i_req = 1'b1;
		i_read = rd;
		i_addr = a;
		i_wdata = d;
		for (n = 0; n < 10 && o_busy !== 1'b1; n++) @(negedge i_clk);
		i_req = 1'b0;
		repeat (40) @(negedge i_clk);
		// Request while busy is ignored
		i_req = 1'b1;
		@(negedge i_clk);
		i_req = 1'b0;
		for (n = 0; n < 400 && o_done !== 1'b1; n++) @(negedge i_clk);
		chk("busy", 16'h0000, {15'h0000, o_busy});
		chk("header", {rd, 4'h0, a}, frame_in[23:8]);
		if (rd) begin
			chk("rdata", {8'h00, mem[a]}, {8'h00, o_rdata});
			chk("sout", {8'h00, mem[a]}, {8'h00, frame_out[7:0]});
		end else begin
			mem[a] = d;
			chk("sin", {8'h00, d}, {8'h00, frame_in[7:0]});
			chk("addr", {5'h00, a}, {5'h00, o_last_addr});
			chk("wdata", {8'h00, d}, {8'h00, o_last_wdata});
		end
		repeat (20) @(negedge i_clk);
		chk("frames", 16'h0001, 16'(frames - f));
		chk("writes", {15'h0000, !rd}, 16'(writes - w));
	endtask : op

	task automatic t_write_edges();
		op(1'b0, 11'h000, 8'ha5);
		op(1'b0, 11'h7ff, 8'h5a);
		op(1'b0, 11'h3c3, 8'hff);
		op(1'b0, 11'h001, 8'h00);
		$display("test write_edges done");
	endtask : t_write_edges

	task automatic t_read_back();
		op(1'b1, 11'h7ff, 8'h00);
		op(1'b1, 11'h000, 8'h00);
		op(1'b1, 11'h3c3, 8'h00);
		op(1'b1, 11'h001, 8'h00);
		$display("test read_back done");
	endtask : t_read_back

	task automatic t_overwrite();
		op(1'b0, 11'h7ff, 8'h81);
		op(1'b1, 11'h7ff, 8'h00);
		op(1'b1, 11'h000, 8'h00);
		$display("test overwrite done");
	endtask : t_overwrite

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (20) @(negedge i_clk);
		i_rst_n = 1'b1;
		t_write_edges();
		t_read_back();
		t_overwrite();
		summarize();
	end

	initial begin
		#2000000;
		failures++;
		summarize();
	end
endmodule : testbench
